// >>> include/mmcr_map.svh
// Register offsets, field positions, reset values and timing figures of the mask/config bank
`ifndef MMCR_MAP_SVH
`define MMCR_MAP_SVH

`define MMCR_OFS_MASK_ONE 8'h43
`define MMCR_OFS_MASK_TWO 8'h44
`define MMCR_OFS_SPARE 8'h45
`define MMCR_OFS_INTR_CLR 8'h46
`define MMCR_OFS_VID_DIV 8'h47
`define MMCR_OFS_VID_TOP 8'h49
`define MMCR_OFS_CFG_TWO 8'h4A

`define MMCR_RST_MASK 8'h00
`define MMCR_RST_SPARE 8'h00
`define MMCR_RST_INTR_CLR 8'h00
`define MMCR_RST_DIV_FIELDS 4'h5
`define MMCR_RST_VID_TOP_HI 7'h40
`define MMCR_RST_CFG_TWO 8'h00

`define MMCR_BIT_INTR_PULSE 7
`define MMCR_BIT_THERMAL_ALARM_N_STATUS 5
`define MMCR_CFG_RSVD_MASK 8'hCF

`define MMCR_INTR_PULSE_MS 20
`define MMCR_SYS_CLK_HZ 100000000
`define MMCR_INTR_PULSE_CYC (`MMCR_INTR_PULSE_MS * (`MMCR_SYS_CLK_HZ / 1000))

`endif

// >>> include/mmcr_pkg.sv
// Types shared by the mask/config register bank
package mmcr_pkg;

  // Register access strobe group from the serial-bus engine
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } mmcr_req_type;

  // Second configuration register layout
  typedef struct packed {
    logic id4_irq_enable;
    logic id3_irq_enable;
    logic [1:0] rsvd;
    logic thermal_acpi_mode;
    logic ext_limit_lock;
    logic int_limit_lock;
    logic thermal_int_mask;
  } mmcr_cfg_type;

  // Intrusion pulse sequencer, Gray-coded along idle -> pulse -> finish
  typedef enum logic [1:0] {
    MMCR_IDLE = 2'b00,
    MMCR_PULSE = 2'b01,
    MMCR_FINISH = 2'b11
  } mmcr_pulse_type;

endpackage : mmcr_pkg

// >>> logic/mmcr_bank.sv
// Interrupt mask, intrusion clear, ID/divisor and second configuration register bank
//
// Notes on behaviour
// [R1] Mask bit one blocks its status bit
// [R2] First mask covers eight measured channels
// [R3] Second mask: 12V, supply2, intrusion, thermal, diodes
// [R4] Masks and intrusion clear reset to zero
// [R5] Spare byte is plain read/write, resets zero
// [R6] Intrusion clear pulses pin low 20 ms
// [R7] Low nibble reads the four ID pins
// [R8] Bits 5:4 pick tach-1 divisor
// [R9] Bits 7:6 pick tach-2 divisor
// [R10] Divisor fields reset to 0101
// [R11] Fifth ID bit read-only, upper bits resettable
// [R12] Thermal mask keeps thermal off interrupt
// [R13] Internal high limit lock is write-once
// [R14] External high limit lock is write-once
// [R15] Bit 3 selects thermal output mode
// [R16] Bit 6 makes ID pin 3 interrupt
// [R17] Bit 7 makes ID pin 4 interrupt
// [R18] Channel-mode select gates ID interrupt inputs
// [R19] Interrupt output driven only when enabled
// [R20] Restore-defaults reloads listed registers
// [R21] Interrupt asserts on any unmasked status
`include "mmcr_map.svh"
`timescale 1ns/1ns
`default_nettype none

module mmcr_bank #(
  parameter int unsigned PULSE_CYCLES = `MMCR_INTR_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire mmcr_pkg::mmcr_req_type reg_req,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two,
  input wire logic int_output_enable,
  input wire logic restore_defaults_bit,
  input wire logic id_pin_irq_select,
  input wire logic [3:0] voltage_id_pins,
  input wire logic voltage_id_top_bit,
  output logic int_alarm_n_o,
  output logic int_alarm_oe,
  output logic intrusion_pin_o,
  output logic intrusion_pin_oe,
  output logic [3:0] tach1_divisor,
  output logic [3:0] tach2_divisor,
  output logic thermal_acpi_mode,
  output logic int_limit_lock,
  output logic ext_limit_lock,
  output logic id3_irq_active,
  output logic id4_irq_active
);

  localparam int unsigned CNT_W = $clog2(PULSE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_reg;
  logic rst_sync_n;

  // Release is synchronised so no flop leaves reset on a different edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Two-bit divisor code to divide ratio 1, 2, 4 or 8
  function automatic logic [3:0] div_ratio(input logic [1:0] code);
    div_ratio = 4'h1 << code;
  endfunction : div_ratio

  function automatic logic hit(input mmcr_pkg::mmcr_req_type r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // Writable registers

  logic [7:0] mask_one_reg;
  logic [7:0] mask_two_reg;
  logic [7:0] spare_reg;
  logic [6:0] intr_clr_low_reg;
  logic intr_req_reg;
  logic [3:0] div_fields_reg;
  logic [6:0] vid_top_hi_reg;
  mmcr_pkg::mmcr_cfg_type cfg_reg;
  mmcr_pkg::mmcr_cfg_type cfg_next;
  mmcr_pkg::mmcr_pulse_type pulse_state_reg;
  logic [CNT_W-1:0] pulse_cnt_reg;

  // Mask registers; restore-defaults wins over a write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_one_reg <= `MMCR_RST_MASK; // see [R4]
      mask_two_reg <= `MMCR_RST_MASK; // see [R4]
    end else if (restore_defaults_bit) begin
      mask_one_reg <= `MMCR_RST_MASK; // see [R20]
      mask_two_reg <= `MMCR_RST_MASK; // see [R20]
    end else begin
      if (hit(reg_req, `MMCR_OFS_MASK_ONE)) begin
        mask_one_reg <= reg_req.wdata; // see [R2]
      end
      if (hit(reg_req, `MMCR_OFS_MASK_TWO)) begin
        mask_two_reg <= reg_req.wdata; // see [R3]
      end
    end
  end

  // Spare byte only exists so old software finds a working location
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      spare_reg <= `MMCR_RST_SPARE; // see [R5]
    end else if (hit(reg_req, `MMCR_OFS_SPARE)) begin
      spare_reg <= reg_req.wdata; // see [R5]
    end
  end

  // Divisor fields and the reserved high bits of the fifth-ID register
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_fields_reg <= `MMCR_RST_DIV_FIELDS; // see [R10]
      vid_top_hi_reg <= `MMCR_RST_VID_TOP_HI; // see [R11]
    end else if (restore_defaults_bit) begin
      div_fields_reg <= `MMCR_RST_DIV_FIELDS; // see [R20]
      vid_top_hi_reg <= `MMCR_RST_VID_TOP_HI; // see [R20]
    end else begin
      if (hit(reg_req, `MMCR_OFS_VID_DIV)) begin
        div_fields_reg <= reg_req.wdata[7:4]; // see [R8] see [R9]
      end
      if (hit(reg_req, `MMCR_OFS_VID_TOP)) begin
        vid_top_hi_reg <= reg_req.wdata[7:1]; // see [R11]
      end
    end
  end

  // Lock bits may only go from zero to one; only power-on clears them
  always_comb begin
    cfg_next = cfg_reg;
    if (hit(reg_req, `MMCR_OFS_CFG_TWO)) begin
      cfg_next = reg_req.wdata & `MMCR_CFG_RSVD_MASK;
      cfg_next.int_limit_lock = cfg_reg.int_limit_lock | reg_req.wdata[1]; // see [R13]
      cfg_next.ext_limit_lock = cfg_reg.ext_limit_lock | reg_req.wdata[2]; // see [R14]
    end
  end

  // Not touched by restore-defaults, so the locks survive it
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_reg <= `MMCR_RST_CFG_TWO;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Intrusion pulse

  // Low bits of the clear register are plain storage
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      intr_clr_low_reg <= 7'(`MMCR_RST_INTR_CLR); // see [R4]
    end else if (restore_defaults_bit) begin
      intr_clr_low_reg <= 7'(`MMCR_RST_INTR_CLR); // see [R20]
    end else if (hit(reg_req, `MMCR_OFS_INTR_CLR)) begin
      intr_clr_low_reg <= reg_req.wdata[6:0];
    end
  end

  // Request bit stays visible until the pulse has finished, then self-clears
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      intr_req_reg <= 1'b0; // see [R4]
    end else if (restore_defaults_bit) begin
      intr_req_reg <= 1'b0; // see [R20]
    end else if (hit(reg_req, `MMCR_OFS_INTR_CLR) && reg_req.wdata[`MMCR_BIT_INTR_PULSE]) begin
      intr_req_reg <= 1'b1; // see [R6]
    end else if (pulse_state_reg == mmcr_pkg::MMCR_FINISH) begin
      intr_req_reg <= 1'b0; // see [R6]
    end
  end

  // A restore aborts a pulse in progress, trading the minimum width for a clean state
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pulse_state_reg <= mmcr_pkg::MMCR_IDLE;
      pulse_cnt_reg <= '0;
    end else if (restore_defaults_bit) begin
      pulse_state_reg <= mmcr_pkg::MMCR_IDLE;
      pulse_cnt_reg <= '0;
    end else begin
      unique case (pulse_state_reg)
        mmcr_pkg::MMCR_IDLE: begin
          if (intr_req_reg) begin
            pulse_state_reg <= mmcr_pkg::MMCR_PULSE;
            pulse_cnt_reg <= CNT_W'(PULSE_CYCLES - 1); // see [R6]
          end
        end
        mmcr_pkg::MMCR_PULSE: begin
          if (pulse_cnt_reg == '0) begin
            pulse_state_reg <= mmcr_pkg::MMCR_FINISH;
          end else begin
            pulse_cnt_reg <= pulse_cnt_reg - CNT_W'(1);
          end
        end
        mmcr_pkg::MMCR_FINISH: begin
          pulse_state_reg <= mmcr_pkg::MMCR_IDLE;
        end
        default: begin
          pulse_state_reg <= mmcr_pkg::MMCR_IDLE;
        end
      endcase
    end
  end

  // Open-drain: only ever pulls low
  assign intrusion_pin_o = 1'b0;
  assign intrusion_pin_oe = (pulse_state_reg == mmcr_pkg::MMCR_PULSE); // see [R6]

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt gating

  logic [15:0] status_all;
  logic [15:0] mask_all;
  logic [15:0] live_bits;
  logic id_irq_any;
  logic int_pending_reg;

  assign status_all = {status_two, status_one};
  assign mask_all = {mask_two_reg, mask_one_reg};

  // Each status bit only counts with its mask bit clear
  for (genvar i = 0; i < 16; i++) begin : g_gate
    if (i == 8 + `MMCR_BIT_THERMAL_ALARM_N_STATUS) begin : g_thermal_alarm_n
      assign live_bits[i] = status_all[i] & ~mask_all[i] & ~cfg_reg.thermal_int_mask; // see [R12]
    end else begin : g_plain
      assign live_bits[i] = status_all[i] & ~mask_all[i]; // see [R1]
    end
  end

  // ID pins become interrupt inputs only with the channel-mode select set
  assign id3_irq_active = id_pin_irq_select & cfg_reg.id3_irq_enable & voltage_id_pins[3]; // see [R16] see [R18]
  assign id4_irq_active = id_pin_irq_select & cfg_reg.id4_irq_enable & voltage_id_top_bit; // see [R17] see [R18]
  assign id_irq_any = id3_irq_active | id4_irq_active;

  // Registered so the pin never glitches on status decode
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_pending_reg <= 1'b0;
    end else begin
      int_pending_reg <= (|live_bits) | id_irq_any; // see [R21]
    end
  end

  assign int_alarm_n_o = 1'b0;
  assign int_alarm_oe = int_pending_reg & int_output_enable; // see [R19]

  ////////////////////////////////////////////////////////////////////////////////
  // Register read and static outputs

  // Read data is captured one edge after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_req.rd;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          `MMCR_OFS_MASK_ONE: reg_rd_data <= mask_one_reg;
          `MMCR_OFS_MASK_TWO: reg_rd_data <= mask_two_reg;
          `MMCR_OFS_SPARE: reg_rd_data <= spare_reg;
          `MMCR_OFS_INTR_CLR: reg_rd_data <= {intr_req_reg, intr_clr_low_reg};
          `MMCR_OFS_VID_DIV: reg_rd_data <= {div_fields_reg, voltage_id_pins}; // see [R7]
          `MMCR_OFS_VID_TOP: reg_rd_data <= {vid_top_hi_reg, voltage_id_top_bit}; // see [R11]
          `MMCR_OFS_CFG_TWO: reg_rd_data <= cfg_reg;
          default: reg_rd_data <= 8'h00;
        endcase
      end
    end
  end

  assign tach1_divisor = div_ratio(div_fields_reg[1:0]); // see [R8]
  assign tach2_divisor = div_ratio(div_fields_reg[3:2]); // see [R9]
  assign thermal_acpi_mode = cfg_reg.thermal_acpi_mode; // see [R15]
  assign int_limit_lock = cfg_reg.int_limit_lock; // see [R13]
  assign ext_limit_lock = cfg_reg.ext_limit_lock; // see [R14]

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  mask_blocks_int_a: assert property ( // see [R1]
    (status_all == mask_all && !id_irq_any) |=> !int_pending_reg)
    else $error("masked status still raised the interrupt");

  unmasked_raises_a: assert property ( // see [R21]
    (status_one[0] && !mask_one_reg[0]) |=> int_pending_reg)
    else $error("unmasked status did not raise the interrupt");

  int_gated_a: assert property ( // see [R19]
    !int_output_enable |-> !int_alarm_oe)
    else $error("interrupt driven while disabled");

  int_lock_sticky_a: assert property ( // see [R13]
    $rose(cfg_reg.int_limit_lock) |=> cfg_reg.int_limit_lock [*8])
    else $error("internal limit lock cleared");

  ext_lock_sticky_a: assert property ( // see [R14]
    cfg_reg.ext_limit_lock |=> cfg_reg.ext_limit_lock)
    else $error("external limit lock cleared");

  pulse_starts_a: assert property ( // see [R6]
    (hit(reg_req, `MMCR_OFS_INTR_CLR) && reg_req.wdata[7] && !restore_defaults_bit
      && pulse_state_reg == mmcr_pkg::MMCR_IDLE) |=> ##1 intrusion_pin_oe)
    else $error("intrusion pulse did not start");

  pulse_width_a: assert property ( // see [R6]
    (pulse_state_reg == mmcr_pkg::MMCR_PULSE && pulse_cnt_reg != '0 && !restore_defaults_bit)
      |=> intrusion_pin_oe && intr_req_reg)
    else $error("intrusion pulse ended early");

  restore_defaults_a: assert property ( // see [R20]
    restore_defaults_bit |=> mask_one_reg == 8'h00 && mask_two_reg == 8'h00
      && div_fields_reg == 4'h5 && !intr_req_reg)
    else $error("restore did not reload defaults");

  id_select_a: assert property ( // see [R18]
    !id_pin_irq_select |-> !id3_irq_active && !id4_irq_active)
    else $error("ID interrupt active without select");

  thermal_alarm_n_mask_a: assert property ( // see [R12]
    cfg_reg.thermal_int_mask |-> !live_bits[8 + `MMCR_BIT_THERMAL_ALARM_N_STATUS])
    else $error("thermal event passed its mask");

  vid_read_a: assert property ( // see [R7]
    (reg_req.rd && reg_req.addr == `MMCR_OFS_VID_DIV)
      |=> reg_rd_valid && reg_rd_data[3:0] == $past(voltage_id_pins))
    else $error("ID nibble read wrong");

  cover_pulse_done_c: cover property (pulse_state_reg == mmcr_pkg::MMCR_FINISH);
  cover_int_drive_c: cover property (int_alarm_oe);
  cover_lock_set_c: cover property ($rose(cfg_reg.ext_limit_lock));
  cover_id_irq_c: cover property (id3_irq_active ##1 id4_irq_active);

endmodule : mmcr_bank

`default_nettype wire

// >>> verification/mmcr_host.sv
// Behavioural serial-bus host issuing single-byte register accesses
`timescale 1ns/1ns
`default_nettype none

module mmcr_host (
  input wire logic clk_sys,
  output var mmcr_pkg::mmcr_req_type reg_req,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  initial reg_req = '0;

  // Write strobe held up to the taking edge; released lines show inverted junk, not old data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys);
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : wr

  // Read strobe taken at one edge; data and valid are looked at in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
    @(negedge clk_sys);
    ok = reg_rd_valid;
    d = reg_rd_data;
  endtask : rd
endmodule : mmcr_host
`default_nettype wire

// >>> verification/mmcr_bank_tb.sv
// Self-checking bench for the mask/config register bank
`timescale 1ns/1ns
`default_nettype none

module mmcr_bank_tb;
  localparam int unsigned P = 8;
  logic clk_sys, arst_n, int_output_enable, restore_defaults_bit, id_pin_irq_select;
  logic voltage_id_top_bit, reg_rd_valid, int_alarm_n_o, int_alarm_oe, intrusion_pin_o;
  logic intrusion_pin_oe, thermal_acpi_mode, int_limit_lock, ext_limit_lock;
  logic id3_irq_active, id4_irq_active;
  logic [7:0] status_one, status_two, reg_rd_data;
  logic [3:0] voltage_id_pins, tach1_divisor, tach2_divisor;
  mmcr_pkg::mmcr_req_type reg_req;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  mmcr_bank #(.PULSE_CYCLES(P)) u_mmcr_bank (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .status_one(status_one), .status_two(status_two), .int_output_enable(int_output_enable),
    .restore_defaults_bit(restore_defaults_bit), .id_pin_irq_select(id_pin_irq_select),
    .voltage_id_pins(voltage_id_pins), .voltage_id_top_bit(voltage_id_top_bit),
    .int_alarm_n_o(int_alarm_n_o), .int_alarm_oe(int_alarm_oe),
    .intrusion_pin_o(intrusion_pin_o), .intrusion_pin_oe(intrusion_pin_oe),
    .tach1_divisor(tach1_divisor), .tach2_divisor(tach2_divisor),
    .thermal_acpi_mode(thermal_acpi_mode), .int_limit_lock(int_limit_lock),
    .ext_limit_lock(ext_limit_lock), .id3_irq_active(id3_irq_active),
    .id4_irq_active(id4_irq_active));
  mmcr_host u_mmcr_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid));

  // Free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Hang guard: whole run needs a few hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // Read and compare one byte, valid strobe included
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_mmcr_host.rd(a, d, ok);
    chk_bit(ok, 1'b1);
    chk_byte(d, exp);
  endtask : rdc

  // Interrupt path needs one registered stage; give it two edges
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic t_reset;
    rdc(8'h43, 8'h00);
    rdc(8'h44, 8'h00);
    rdc(8'h45, 8'h00);
    rdc(8'h46, 8'h00);
    rdc(8'h47, {4'h5, voltage_id_pins});
    rdc(8'h49, {7'h40, voltage_id_top_bit});
    rdc(8'h4A, 8'h00);
    chk_byte({tach1_divisor, tach2_divisor}, 8'h22);
    rdc(8'h48, 8'h00);
  endtask : t_reset

  // Back-to-back writes, reserved bits included, then readback
  task automatic t_rw;
    u_mmcr_host.wr(8'h43, 8'h5A);
    u_mmcr_host.wr(8'h44, 8'h0C);
    u_mmcr_host.wr(8'h45, 8'hA5);
    u_mmcr_host.wr(8'h46, 8'h7F);
    rdc(8'h43, 8'h5A);
    rdc(8'h44, 8'h0C);
    rdc(8'h45, 8'hA5);
    rdc(8'h46, 8'h7F);
    chk_bit(intrusion_pin_oe, 1'b0);
    u_mmcr_host.wr(8'h43, 8'h00);
    u_mmcr_host.wr(8'h44, 8'h00);
  endtask : t_rw

  // Every divisor code on both fields; low nibble ignores writes and follows the pins
  task automatic t_div;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      voltage_id_pins <= k[3:0] ^ 4'h9;
      u_mmcr_host.wr(8'h47, {k[1:0], ~k[1:0], 4'hF});
      rdc(8'h47, {k[1:0], ~k[1:0], k[3:0] ^ 4'h9});
      chk_byte({tach1_divisor, tach2_divisor}, {4'h1 << (3 - k), 4'h1 << k});
    end
    @(posedge clk_sys);
    voltage_id_top_bit <= 1'b0;
    u_mmcr_host.wr(8'h49, 8'hFF);
    rdc(8'h49, 8'hFE);
  endtask : t_div

  // Each status bit alone: raises, survives other masks, blocked by its own
  task automatic t_int;
    @(posedge clk_sys);
    int_output_enable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      {status_two, status_one} <= 16'h0001 << i;
      settle();
      chk_bit(int_alarm_oe, 1'b1);
      u_mmcr_host.wr(i < 8 ? 8'h43 : 8'h44, ~(8'h01 << (i % 8)));
      settle();
      chk_bit(int_alarm_oe, 1'b1);
      u_mmcr_host.wr(i < 8 ? 8'h43 : 8'h44, 8'h01 << (i % 8));
      settle();
      chk_bit(int_alarm_oe, 1'b0);
      u_mmcr_host.wr(i < 8 ? 8'h43 : 8'h44, 8'h00);
    end
    @(posedge clk_sys);
    int_output_enable <= 1'b0;
    #1;
    chk_bit(int_alarm_oe, 1'b0);
    chk_bit(int_alarm_n_o, 1'b0);
  endtask : t_int

  // Thermal mask and output mode; bits 5:4 stay zero
  task automatic t_cfg;
    @(posedge clk_sys);
    int_output_enable <= 1'b1;
    status_two <= 8'h20;
    u_mmcr_host.wr(8'h4A, 8'h39);
    settle();
    chk_bit(int_alarm_oe, 1'b0);
    chk_bit(thermal_acpi_mode, 1'b1);
    rdc(8'h4A, 8'h09);
    u_mmcr_host.wr(8'h4A, 8'h00);
    settle();
    chk_bit(int_alarm_oe, 1'b1);
    chk_bit(thermal_acpi_mode, 1'b0);
    @(posedge clk_sys);
    status_two <= 8'h00;
  endtask : t_cfg

  // ID pins as interrupt inputs, gated by the channel-mode select
  task automatic t_idirq;
    @(posedge clk_sys);
    voltage_id_pins <= 4'h8;
    voltage_id_top_bit <= 1'b1;
    u_mmcr_host.wr(8'h4A, 8'h40);
    settle();
    chk_byte({6'h00, id4_irq_active, id3_irq_active}, 8'h00);
    @(posedge clk_sys);
    id_pin_irq_select <= 1'b1;
    settle();
    chk_byte({6'h00, id4_irq_active, id3_irq_active}, 8'h01);
    chk_bit(int_alarm_oe, 1'b1);
    u_mmcr_host.wr(8'h4A, 8'h80);
    settle();
    chk_byte({6'h00, id4_irq_active, id3_irq_active}, 8'h02);
    @(posedge clk_sys);
    id_pin_irq_select <= 1'b0;
    u_mmcr_host.wr(8'h4A, 8'h00);
  endtask : t_idirq

  // Lock bits stick once set; the rest of the register stays writable
  task automatic t_lock;
    u_mmcr_host.wr(8'h4A, 8'h06);
    u_mmcr_host.wr(8'h4A, 8'h08);
    #1;
    chk_byte({6'h00, ext_limit_lock, int_limit_lock}, 8'h03);
    rdc(8'h4A, 8'h0E);
  endtask : t_lock

  // Pulse length counted at mid-cycle; request bit drops afterwards
  task automatic t_pulse;
    int n;
    n = 0;
    u_mmcr_host.wr(8'h46, 8'h80);
    repeat (P + 8) begin
      @(negedge clk_sys);
      n += int'(intrusion_pin_oe === 1'b1);
    end
    chk_byte(n[7:0], P[7:0]);
    chk_bit(intrusion_pin_o, 1'b0);
    rdc(8'h46, 8'h00);
  endtask : t_pulse

  // Restore-defaults mid-pulse reloads listed registers and leaves the locks alone
  task automatic t_restore;
    u_mmcr_host.wr(8'h43, 8'hFF);
    u_mmcr_host.wr(8'h44, 8'hFF);
    u_mmcr_host.wr(8'h47, 8'hF0);
    u_mmcr_host.wr(8'h49, 8'h00);
    u_mmcr_host.wr(8'h46, 8'h80);
    @(posedge clk_sys);
    restore_defaults_bit <= 1'b1;
    @(posedge clk_sys);
    restore_defaults_bit <= 1'b0;
    settle();
    chk_bit(intrusion_pin_oe, 1'b0);
    rdc(8'h43, 8'h00);
    rdc(8'h44, 8'h00);
    rdc(8'h46, 8'h00);
    rdc(8'h47, {4'h5, voltage_id_pins});
    rdc(8'h49, {7'h40, voltage_id_top_bit});
    rdc(8'h4A, 8'h0E);
    // Only a power-on reset frees the locks and clears the spare byte
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_byte({6'h00, ext_limit_lock, int_limit_lock}, 8'h00);
    rdc(8'h4A, 8'h00);
    rdc(8'h45, 8'h00);
  endtask : t_restore

  // Main sequence
  initial begin
    arst_n = 1'b0;
    int_output_enable = 1'b0;
    restore_defaults_bit = 1'b0;
    id_pin_irq_select = 1'b0;
    voltage_id_top_bit = 1'b1;
    voltage_id_pins = 4'hA;
    status_one = 8'h00;
    status_two = 8'h00;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_rw();
    t_div();
    t_int();
    t_cfg();
    t_idirq();
    t_lock();
    t_pulse();
    t_restore();
    test_done();
  end
endmodule : mmcr_bank_tb
`default_nettype wire
